// ==== hw/sfc_frontend.sv ====
// Purpose: Command front end of a serial flash: frames, decodes and answers link commands.
// Assumes: The link clock is slow enough to be oversampled by mclk (at least 8 mclk per phase).
// Notes: Array read bytes must reach the FIFO before the next link falling edge.
`timescale 1ns/1ps

module sfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock, reset and flush.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q, cnt_d;
    logic full_q;
    logic push, pop;

    assign push = in_valid && !full_q;
    assign pop = out_ready && (cnt_q != '0);
    assign in_ready = !full_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
        end else begin
            wp_q <= push ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
            rp_q <= pop ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
            cnt_q <= cnt_d;
            full_q <= (cnt_d == (AW+1)'(DEPTH));
        end
    end
endmodule // sfc_fifo

module sfc_frontend #(
    parameter int DEPTH = sfc_pkg::RD_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Serial link pins.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // Status overlay.
    input wire logic busy,
    input wire logic [15:0] sr_nv,
    output logic write_latch,
    output logic addr_width_flag,
    output logic ext_addr_lsb,
    // Commands toward the engines.
    output logic cmd_valid,
    output logic cmd_drop,
    output logic [7:0] cmd_op,
    output logic [31:0] cmd_addr,
    output logic pg_valid,
    output logic [7:0] pg_data,
    // Array read stream.
    output logic rd_req,
    output logic rd_sfdp,
    output logic rd_active,
    output logic [31:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic rd_ready
);
    import sfc_pkg::*;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [2:0] cs_q, sc_q;
    logic [3:0] io1_q, io2_q;
    logic sel, cs_rise, sc_rise, sc_fall;
    sfc_phase_type ph_q;
    sfc_dec_type dec_q, dec_n;
    logic [7:0] op_q, in_sh_q, byte_n, osh_q, cur, src, regb;
    logic [3:0] ibit_q, ibit_n, step, nbyte_q, need;
    logic [2:0] ccnt_q, arem_q, orem_q;
    logic [31:0] addr_q, addr_n, addr_src;
    logic bdone, go_out, four_q, ear_q, wl_q, bnd_ok, exec_ok, pop, f_valid;
    logic [7:0] f_data;
    logic [15:0] sr;

    // Pins pass two flip-flops; the third stage only serves edge detection.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q <= 3'h7;
            sc_q <= 3'h0;
            io1_q <= 4'h0;
            io2_q <= 4'h0;
        end else begin
            cs_q <= {cs_q[1:0], cs_n};
            sc_q <= {sc_q[1:0], sclk};
            io1_q <= io_in;
            io2_q <= io1_q;
        end
    end

    assign sel = !cs_q[1];
    assign cs_rise = cs_q[1] && !cs_q[2];
    assign sc_rise = sel && sc_q[1] && !sc_q[2];
    assign sc_fall = sel && !sc_q[1] && sc_q[2];

    assign step = (ph_q == PH_DAT && dec_q.qin) ? 4'h4 : 4'h1;
    assign ibit_n = ibit_q + step;
    assign bdone = sc_rise && ibit_n[3];
    assign byte_n = (step == 4'h4) ? {in_sh_q[3:0], io2_q} : {in_sh_q[6:0], io2_q[0]};
    assign dec_n = sfc_decode(byte_n, four_q);
    assign addr_n = {addr_q[23:0], byte_n};
    assign addr_src = (ph_q == PH_ADR) ? addr_n : addr_q;
    assign go_out = bdone && dec_q.arr && ((ph_q == PH_DMY) ||
                    (ph_q == PH_ADR && arem_q == 3'h1 && !dec_q.dmy));
    assign need = {1'b0, dec_q.nadr} + 4'h1;
    assign bnd_ok = dec_q.bnd && (nbyte_q != 4'h0) && (ccnt_q == 3'h0) &&
                    (dec_q.data ? (nbyte_q > need) : (nbyte_q == need));
    assign exec_ok = bnd_ok && (!dec_q.wl || wl_q);

    // Input framing: opcode, address, dummy and data phases.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= PH_OPC;
            ibit_q <= 4'h0;
            ccnt_q <= 3'h0;
            nbyte_q <= 4'h0;
            arem_q <= 3'h0;
            in_sh_q <= 8'h00;
            op_q <= 8'h00;
            dec_q <= '0;
            addr_q <= 32'h0000_0000;
        end else if (!sel) begin
            ph_q <= PH_OPC;
            ibit_q <= 4'h0;
            ccnt_q <= 3'h0;
            nbyte_q <= 4'h0;
        end else if (sc_rise) begin
            ccnt_q <= ccnt_q + 3'h1;
            ibit_q <= bdone ? 4'h0 : ibit_n;
            in_sh_q <= byte_n;
            if (bdone) begin
                nbyte_q <= (nbyte_q == 4'hF) ? nbyte_q : nbyte_q + 4'h1;
                case (ph_q)
                    PH_OPC: begin
                        op_q <= byte_n;
                        dec_q <= dec_n;
                        arem_q <= dec_n.nadr;
                        ph_q <= (dec_n.nadr != 3'h0) ? PH_ADR : sfc_after_addr(dec_n);
                    end
                    PH_ADR: begin
                        addr_q <= addr_n;
                        arem_q <= arem_q - 3'h1;
                        if (arem_q == 3'h1) begin
                            ph_q <= sfc_after_addr(dec_q);
                        end
                    end
                    PH_DMY: ph_q <= PH_OUT;
                    default: ph_q <= ph_q;
                endcase
            end
        end
    end

    // Address mode and extended address byte.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            four_q <= 1'b0;
            ear_q <= EAR_RESET[0];
        end else if (bdone) begin
            if (ph_q == PH_OPC && byte_n == OP_EN4B) begin
                four_q <= 1'b1;
            end else if (ph_q == PH_OPC && byte_n == OP_EX4B) begin
                four_q <= 1'b0;
            end else if (ph_q == PH_DAT && op_q == OP_WR_EAR && nbyte_q == 4'h1) begin
                ear_q <= byte_n[0];
            end
        end
    end

    // Write latch changes only on an accepted, byte-aligned frame end.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wl_q <= 1'b0;
        end else if (cs_rise && exec_ok) begin
            wl_q <= (op_q == OP_WR_EN);
        end
    end

    // Command, program data and read request outputs.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_drop <= 1'b0;
            cmd_op <= 8'h00;
            cmd_addr <= 32'h0000_0000;
            pg_valid <= 1'b0;
            pg_data <= 8'h00;
            rd_req <= 1'b0;
            rd_sfdp <= 1'b0;
            rd_active <= 1'b0;
            rd_addr <= 32'h0000_0000;
        end else begin
            cmd_valid <= cs_rise && exec_ok && !(op_q inside {OP_WR_EN, OP_WR_DIS});
            cmd_drop <= cs_rise && (nbyte_q != 4'h0) && dec_q.bnd && !exec_ok;
            if (cs_rise) begin
                cmd_op <= op_q;
                cmd_addr <= sfc_full_addr(addr_q, dec_q.nadr, 1'b0, ear_q);
            end
            pg_valid <= bdone && ph_q == PH_DAT && wl_q && (dec_q.wl);
            pg_data <= byte_n;
            rd_req <= go_out;
            rd_active <= sel && (go_out || rd_active);
            if (go_out) begin
                rd_addr <= sfc_full_addr(addr_src, dec_q.nadr, dec_q.sfdp, ear_q);
                rd_sfdp <= dec_q.sfdp;
            end
        end
    end

    sfc_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_rd_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .flush(!rd_active),
        .in_valid(rd_valid),
        .in_ready(rd_ready),
        .in_data(rd_data),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );

    always_comb begin
        sr = sr_nv;
        sr[SR_BUSY_BIT] = busy;
        sr[SR_WL_BIT] = wl_q;
        sr[SR_AW_BIT] = four_q;
        if (op_q == OP_RD_EAR) begin
            regb = {7'h00, ear_q};
        end else if (op_q == OP_RD_SR1) begin
            regb = sr[7:0];
        end else begin
            regb = sr[15:8];
        end
        src = dec_q.arr ? (f_valid ? f_data : IDLE_FILL) : regb;
        cur = (orem_q == 3'h0) ? src : osh_q;
    end

    assign pop = sc_fall && ph_q == PH_OUT && orem_q == 3'h0 && dec_q.arr;

    // Output shifter: new bits appear on falling link clock edges.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
            osh_q <= 8'h00;
            orem_q <= 3'h0;
        end else if (!sel) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
            orem_q <= 3'h0;
        end else if (sc_fall && ph_q == PH_OUT) begin
            osh_q <= cur << dec_q.lanes;
            case (dec_q.lanes)
                LN4: begin
                    io_out <= cur[7:4];
                    io_oe <= 4'hF;
                    orem_q <= (orem_q == 3'h0) ? 3'h1 : orem_q - 3'h1;
                end
                LN2: begin
                    io_out <= {2'h0, cur[7:6]};
                    io_oe <= 4'h3;
                    orem_q <= (orem_q == 3'h0) ? 3'h3 : orem_q - 3'h1;
                end
                default: begin
                    io_out <= {2'h0, cur[7], 1'b0};
                    io_oe <= 4'h2;
                    orem_q <= (orem_q == 3'h0) ? 3'h7 : orem_q - 3'h1;
                end
            endcase
        end
    end

    assign write_latch = wl_q;
    assign addr_width_flag = four_q;
    assign ext_addr_lsb = ear_q;

    a_ear_write: assert property ((bdone && ph_q == PH_DAT && op_q == OP_WR_EAR && nbyte_q == 4'h1)
        |=> ext_addr_lsb == $past(byte_n[0]) && ext_addr_lsb == cur[0] | !(op_q == OP_RD_EAR))
        else $error("extended address byte not stored");
    a_mode_enter: assert property ((bdone && ph_q == PH_OPC && byte_n == OP_EN4B) |=> addr_width_flag)
        else $error("four byte mode not entered");
    a_upper_bit: assert property ((go_out && dec_q.nadr == ADR3 && !dec_q.sfdp)
        |=> rd_req && rd_addr[24] == $past(ear_q) && rd_addr[31:25] == 7'h00)
        else $error("address bit 24 not taken from extended register");
    a_dummy_count: assert property (rd_req |-> nbyte_q == need + {3'h0, dec_q.dmy})
        else $error("read started after wrong byte count");
    a_bnd_reject: assert property ((cs_rise && dec_q.bnd && ccnt_q != 3'h0)
        |=> !cmd_valid && $stable(write_latch))
        else $error("unaligned write command acted on");
    a_latch_guard: assert property ((cmd_valid && dec_q.wl) |-> $past(write_latch) && !write_latch)
        else $error("write command ran without the latch");
    a_deselect_off: assert property (!sel |=> io_oe == 4'h0)
        else $error("output driven while deselected");
    a_out_edge: assert property ($changed(io_out) |-> $past(sc_fall || !sel))
        else $error("output changed off a falling edge");
    a_aw_status: assert property ((sc_fall && ph_q == PH_OUT && orem_q == 3'h0 && op_q == OP_RD_SR2)
        |=> osh_q[4] == $past(four_q))
        else $error("address width flag wrong in status");
endmodule // sfc_frontend

// ==== hw/sfc_pkg.sv ====
// Purpose: Constants, types and decode helpers of the serial flash command front end.
// Assumes: Opcodes are judged one whole byte at a time.
// Notes: Lane counts double as the output shift amounts.
package sfc_pkg;
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_RD_SR1 = 8'h05;
    localparam logic [7:0] OP_RD_SR2 = 8'h35;
    localparam logic [7:0] OP_WR_SR = 8'h01;
    localparam logic [7:0] OP_RD_EAR = 8'hC8;
    localparam logic [7:0] OP_WR_EAR = 8'hC5;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_READ4 = 8'h13;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_FAST4 = 8'h0C;
    localparam logic [7:0] OP_DOUT = 8'h3B;
    localparam logic [7:0] OP_DOUT4 = 8'h3C;
    localparam logic [7:0] OP_QOUT = 8'h6B;
    localparam logic [7:0] OP_QOUT4 = 8'h6C;
    localparam logic [7:0] OP_SFDP = 8'h5A;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_PP4 = 8'h12;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_QPP4 = 8'h34;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_SE4 = 8'h21;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE32_4 = 8'h5C;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_BE64_4 = 8'hDC;
    localparam logic [7:0] OP_CE1 = 8'hC7;
    localparam logic [7:0] OP_CE2 = 8'h60;
    localparam logic [7:0] OP_DPD = 8'hB9;
    localparam logic [7:0] OP_EN4B = 8'hB7;
    localparam logic [7:0] OP_EX4B = 8'hE9;
    localparam logic [2:0] ADR3 = 3'h3;
    localparam logic [2:0] ADR4 = 3'h4;
    localparam logic [2:0] LN1 = 3'h1;
    localparam logic [2:0] LN2 = 3'h2;
    localparam logic [2:0] LN4 = 3'h4;
    localparam logic [7:0] EAR_RESET = 8'h00;
    localparam logic [7:0] IDLE_FILL = 8'hFF;
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WL_BIT = 1;
    localparam int SR_AW_BIT = 11;
    localparam int RD_FIFO_DEPTH = 32;

    typedef enum logic [5:0] {
        PH_OPC = 6'b000001,
        PH_ADR = 6'b000010,
        PH_DMY = 6'b000100,
        PH_DAT = 6'b001000,
        PH_OUT = 6'b010000,
        PH_END = 6'b100000
    } sfc_phase_type;

    typedef struct packed {
        logic [2:0] nadr;
        logic dmy;
        logic arr;
        logic sfdp;
        logic [2:0] lanes;
        logic bnd;
        logic wl;
        logic data;
        logic qin;
        logic rreg;
    } sfc_dec_type;

    function automatic sfc_dec_type sfc_decode(input logic [7:0] op, input logic four);
        sfc_dec_type d;
        logic [2:0] n;
        d = '0;
        n = four ? ADR4 : ADR3;
        d.lanes = LN1;
        case (op)
            OP_READ, OP_FAST, OP_DOUT, OP_QOUT: begin
                d.nadr = n;
                d.arr = 1'b1;
            end
            OP_READ4, OP_FAST4, OP_DOUT4, OP_QOUT4: begin
                d.nadr = ADR4;
                d.arr = 1'b1;
            end
            OP_SFDP: begin
                d.nadr = ADR3;
                d.arr = 1'b1;
                d.sfdp = 1'b1;
            end
            OP_PP, OP_QPP, OP_SE, OP_BE32, OP_BE64: begin
                d.nadr = n;
                d.bnd = 1'b1;
                d.wl = 1'b1;
            end
            OP_PP4, OP_QPP4, OP_SE4, OP_BE32_4, OP_BE64_4: begin
                d.nadr = ADR4;
                d.bnd = 1'b1;
                d.wl = 1'b1;
            end
            OP_CE1, OP_CE2, OP_WR_SR: begin
                d.bnd = 1'b1;
                d.wl = 1'b1;
            end
            OP_WR_EN, OP_WR_DIS, OP_DPD: d.bnd = 1'b1;
            OP_RD_SR1, OP_RD_SR2, OP_RD_EAR: d.rreg = 1'b1;
            default: d.nadr = 3'h0;
        endcase
        d.dmy = op inside {OP_FAST, OP_FAST4, OP_DOUT, OP_DOUT4, OP_QOUT, OP_QOUT4, OP_SFDP};
        d.data = op inside {OP_PP, OP_PP4, OP_QPP, OP_QPP4, OP_WR_SR, OP_WR_EAR};
        d.qin = op inside {OP_QPP, OP_QPP4};
        if (op inside {OP_DOUT, OP_DOUT4}) begin
            d.lanes = LN2;
        end else if (op inside {OP_QOUT, OP_QOUT4}) begin
            d.lanes = LN4;
        end
        return d;
    endfunction

    function automatic sfc_phase_type sfc_after_addr(input sfc_dec_type d);
        if (d.dmy) begin
            return PH_DMY;
        end else if (d.arr || d.rreg) begin
            return PH_OUT;
        end else if (d.data) begin
            return PH_DAT;
        end
        return PH_END;
    endfunction

    function automatic logic [31:0] sfc_full_addr(input logic [31:0] a, input logic [2:0] nadr,
                                                  input logic sfdp, input logic ea);
        return (nadr == ADR4) ? a : {7'h00, ea & ~sfdp, a[23:0]};
    endfunction
endpackage

// ==== sim/serial_flash_command_frontend_tb.sv ====
// Purpose: Self-checking bench of the serial flash command front end.
// Assumes: Array side streams bytes A0, A1, ... from each read start.
// Notes: Status bits other than the overlaid ones are held at A5A5.
`timescale 1ns/1ps

module serial_flash_command_frontend_tb;
    import sfc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, rd_valid = 1'b0, write_latch, addr_width_flag, ext_addr_lsb;
    logic cmd_valid, cmd_drop, pg_valid, rd_req, rd_sfdp, rd_active, rd_ready;
    logic [3:0] io_in, io_out, io_oe, oe_or;
    logic [7:0] cmd_op, pg_data, rd_data = 8'h00, seq, op_seen, pg_seen;
    logic [31:0] cmd_addr, rd_addr, adr_seen, ra_seen;
    logic sf_seen, full_seen = 1'b0;
    int nv, nd, err_total = 0, num_checks = 0;

    always #2.5 mclk = ~mclk;

    sfc_host_model host_u (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out));

    sfc_frontend #(.DEPTH(RD_FIFO_DEPTH)) dut_u (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .busy(1'b0), .sr_nv(16'hA5A5),
        .write_latch(write_latch), .addr_width_flag(addr_width_flag), .ext_addr_lsb(ext_addr_lsb),
        .cmd_valid(cmd_valid), .cmd_drop(cmd_drop), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .pg_valid(pg_valid), .pg_data(pg_data), .rd_req(rd_req), .rd_sfdp(rd_sfdp),
        .rd_active(rd_active), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_ready(rd_ready));

    // Array model: keeps pushing while a read is open, so the FIFO fills and stalls.
    always @(posedge mclk) begin
        seq <= (!rd_active) ? 8'hA0 : (rd_valid && rd_ready) ? seq + 8'h01 : seq;
        if (cmd_valid) begin
            nv++;
            op_seen = cmd_op;
            adr_seen = cmd_addr;
        end
        if (cmd_drop) nd++;
        if (pg_valid) pg_seen = pg_data;
        if (rd_req) begin
            ra_seen = rd_addr;
            sf_seen = rd_sfdp;
        end
        if (rd_active && !rd_ready) full_seen = 1'b1;
        oe_or = oe_or | io_oe;
    end

    always @(negedge mclk) begin
        rd_valid <= rd_active;
        rd_data <= seq;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] op, input logic [7:0] a [$], input int n, input int ln, input logic [31:0] ea);
        oe_or = 4'h0;
        host_u.frame({op, a}, n, ln, 0);
        chk("read addr", ea, ra_seen);
        for (int i = 0; i < n; i++) chk("read byte", 8'hA0 + i, host_u.rx[i]);
    endtask

    task automatic t_ext();
        host_u.frame('{OP_WR_EAR, 8'h01}, 0, 1, 0);
        chk("ext bit", 1, ext_addr_lsb);
        host_u.frame('{OP_RD_EAR}, 1, 1, 0);
        chk("ext read", 8'h01, host_u.rx[0]);
        rd(OP_READ, '{8'h12, 8'h34, 8'h56}, 2, 1, 32'h01123456);
        host_u.frame('{OP_WR_EAR, 8'h00}, 0, 1, 0);
        rd(OP_READ, '{8'h12, 8'h34, 8'h56}, 1, 1, 32'h00123456);
        $display("test ext done");
    endtask

    task automatic t_four();
        host_u.frame('{OP_WR_EAR, 8'h01}, 0, 1, 0);
        host_u.frame('{OP_EN4B}, 0, 1, 0);
        chk("width flag", 1, addr_width_flag);
        host_u.frame('{OP_RD_SR2}, 1, 1, 0);
        chk("status 2", 8'hAD, host_u.rx[0]);
        rd(OP_READ, '{8'h02, 8'h34, 8'h56, 8'h78}, 1, 1, 32'h02345678);
        rd(OP_FAST4, '{8'h0F, 8'h00, 8'h00, 8'h10, 8'h00}, 2, 1, 32'h0F000010);
        rd(OP_READ4, '{8'h00, 8'hAB, 8'hCD, 8'hEF}, 40, 1, 32'h00ABCDEF);
        chk("fifo stall", 1, full_seen);
        rd(OP_DOUT4, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 2, 32'h01000000);
        chk("dual oe", 4'h3, oe_or);
        rd(OP_QOUT4, '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00}, 3, 4, 32'h00000040);
        chk("quad oe", 4'hF, oe_or);
        host_u.frame('{OP_EX4B}, 0, 1, 0);
        chk("width flag", 0, addr_width_flag);
        rd(OP_SFDP, '{8'h00, 8'h00, 8'h30, 8'h00}, 2, 1, 32'h00000030);
        chk("sfdp flag", 1, sf_seen);
        $display("test four done");
    endtask

    task automatic t_write();
        logic [7:0] ops [3] = '{OP_SE4, OP_BE32_4, OP_BE64_4};
        nv = 0;
        nd = 0;
        host_u.frame('{OP_SE4, 8'h00, 8'h01, 8'h00, 8'h00}, 0, 1, 0);
        chk("refused", 1, nd);
        host_u.frame('{OP_WR_EN}, 0, 1, 0);
        chk("latch set", 1, write_latch);
        host_u.frame('{OP_PP4, 8'h00, 8'h00, 8'h01, 8'h00, 8'h5A}, 0, 1, 3);
        chk("partial", 2, nd);
        chk("latch kept", 1, write_latch);
        host_u.frame('{OP_PP4, 8'h01, 8'h00, 8'h02, 8'h00, 8'h3C}, 0, 1, 0);
        chk("program", 32'h12000200, {op_seen, adr_seen[23:0]});
        chk("page byte", 8'h3C, pg_seen);
        chk("latch clear", 0, write_latch);
        for (int i = 0; i < 3; i++) begin
            host_u.frame('{OP_WR_EN}, 0, 1, 0);
            host_u.frame('{ops[i], 8'h01, 8'h02, 8'h03, 8'h04}, 0, 1, 0);
            chk("erase op", ops[i], op_seen);
            chk("erase addr", 32'h01020304, adr_seen);
        end
        chk("accepted", 4, nv);
        host_u.frame('{OP_WR_EN}, 0, 1, 0);
        host_u.frame('{OP_WR_DIS}, 0, 1, 4);
        chk("unaligned", 1, write_latch);
        $display("test write done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_ext();
        t_four();
        t_write();
        summarize();
    end

    initial begin
        #400us;
        err_total++;
        summarize();
    end
endmodule // serial_flash_command_frontend_tb

// ==== sim/sfc_host_model.sv ====
// Purpose: Host side of the serial link: frames commands and collects answer bytes.
// Assumes: Mode 0, link clock idle low, 80 ns link period made from mclk falling edges.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/1ps

module sfc_host_model (
    // Clock.
    input wire logic mclk,
    // Link pins.
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out
);
    logic [7:0] rx [$];

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_in = 4'h5;
    end

    task automatic half();
        repeat (8) @(negedge mclk);
    endtask

    task automatic frame(input logic [7:0] tx [$], input int nrd, input int lanes, input int xbits);
        logic [7:0] b;
        int j;
        int k;
        rx = {};
        b = 8'h00;
        cs_n = 1'b0;
        half();
        for (j = 0; j < tx.size() * 8 + xbits; j++) begin
            io_in[0] = (j < tx.size() * 8) ? tx[j / 8][7 - j % 8] : 1'b1;
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        for (j = 0; j < nrd; j++) begin
            for (k = 0; k < 8 / lanes; k++) begin
                io_in = ~io_in;
                half();
                sclk = 1'b1;
                b = (lanes == 4) ? {b[3:0], io_out} : (lanes == 2) ? {b[5:0], io_out[1:0]} : {b[6:0], io_out[1]};
                half();
                sclk = 1'b0;
            end
            rx.push_back(b);
        end
        half();
        cs_n = 1'b1;
        io_in = ~io_in;
        half();
    endtask
endmodule // sfc_host_model
